/* shared/clock_output_defines.vh */
/*
 Constants for the clock output control block: register offsets, field
 positions, reset values and timing counts. Assumes a 40 MHz block clock.
*/
`ifndef CLOCK_OUTPUT_DEFINES_VH
`define CLOCK_OUTPUT_DEFINES_VH

`define CLK_PERIOD_PS        25000
`define REG_PLL_ENABLE       8'h00
`define REG_SPREAD_CTRL      8'h04
`define REG_OUTPUT_ENABLE    8'h08
`define REG_OUTPUT_CTRL      8'h0C
`define REG_STATUS           8'h10
`define RST_PLL_ENABLE       8'hEF
`define RST_SPREAD_CTRL      8'hC0
`define RST_OUTPUT_ENABLE    8'hFF
`define RST_OUTPUT_CTRL      8'h30
`define SPREAD_EN_BIT        6
`define SPREAD_SEL_LSB       3
`define OE_CPU0_BIT          7
`define OE_SRC0_BIT          4
`define OE_DOT_BIT           1
`define OE_LCD_BIT           0
`define OE_REF_BIT           5
`define CPU_RESTART_NS       10
`define SRC_DRIVE_NS         15
`define PD_DRIVE_US          300
`define STAB_US              1800
`define SS_MOD_MIN_KHZ       30
`define SS_MOD_MAX_KHZ       33
`define CPU_RESTART_CYC      ((`CPU_RESTART_NS * 1000) / `CLK_PERIOD_PS)
`define SRC_DRIVE_CYC        ((`SRC_DRIVE_NS * 1000) / `CLK_PERIOD_PS)
`define PD_DRIVE_CYC         ((`PD_DRIVE_US * 1000000) / `CLK_PERIOD_PS)
`define STAB_CYC             ((`STAB_US * 1000000) / `CLK_PERIOD_PS)
`define SS_HALF_CYC          ((1000000000 / (`SS_MOD_MIN_KHZ + `SS_MOD_MAX_KHZ)) / `CLK_PERIOD_PS)
`define SS_STEP_CYC          ((`SS_HALF_CYC + 32) / 64)
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

/* hw/clock_output_control.v */
/*
 Output gating and control for a multi-output clock generator, with its
 control registers on an AXI4-Lite slave. Assumes aclk at 40 MHz, pins
 asynchronous to aclk, and clock phases per output supplied by the caller.
*/
// What this block does
// - Serial-reference request low enables its output; high disables it.
// - Select pins C,B decode to CPU 133.33, 166.67, 100, 66.67 MHz.
// - Three-bit field picks panel down-spread or centre-spread amount.
// - Spread profile is a triangle at 30 to 33 kHz.
// - CPU pair runs, holds true high on stop, or both low.
// - Other pairs go low on power-down or disable; request stops serial-reference only.
// - Stopped CPU output restarts on the fifth aclk edge after stop release (100 to 125 ns), not within 10 ns.
// - Serial-reference output drives on the fifth aclk edge after request assertion (100 to 125 ns), not within 15 ns.
// - Differential outputs enable on the 12006th aclk edge after power-down release (300.125 to 300.15 us), not within 300 us.
// - First stable clock on the 72002nd aclk edge after reset release or the 72006th after power-down release, not within 1.8 ms.
// - Power-down is asynchronous, active high, and drives every clock output low; registers and AXI access stay up.
// - CPU stop halts only outputs marked stoppable.
// - Spread select only acts when panel spread enable is set.
`timescale 1ns/1ps
`include "clock_output_defines.vh"

module clock_output_control #(
    parameter PD_DRIVE_CYCLES = `PD_DRIVE_CYC,
    parameter STAB_CYCLES     = `STAB_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        power_down,
    input  wire        cpu_stop_n,
    input  wire [2:0]  serial_ref_request_n,
    input  wire        cpu_freq_select_b,
    input  wire        cpu_freq_select_c,
    input  wire        cpu_phase,
    input  wire        serial_ref_phase,
    input  wire        display_phase,
    input  wire        panel_phase,
    input  wire        ref_phase,
    output reg  [2:0]  cpu_true,
    output reg  [2:0]  cpu_comp,
    output reg  [2:0]  serial_ref_true,
    output reg  [2:0]  serial_ref_comp,
    output reg         display_96m_true,
    output reg         display_96m_comp,
    output reg         panel_spread_true,
    output reg         panel_spread_comp,
    output reg         ref_out,
    output reg  [1:0]  cpu_freq_code,
    output reg  [7:0]  cpu_freq_mhz,
    output reg  [2:0]  spread_code,
    output reg         spread_centre,
    output reg  [6:0]  spread_profile,
    output reg         clocks_stable
);

    localparam [1:0] ST_DOWN   = 2'b00;
    localparam [1:0] ST_WAKE   = 2'b01;
    localparam [1:0] ST_DRIVE  = 2'b10;
    localparam [1:0] ST_STABLE = 2'b11;

    reg [2:0]  pd_s_q;
    reg [2:0]  stop_s_q;
    reg [2:0]  req_s_q [0:2];
    reg [2:0]  fsb_s_q;
    reg [2:0]  fsc_s_q;
    reg        pd_q;
    reg        stop_n_q;
    reg [2:0]  req_n_q;
    reg [7:0]  pll_en_q;
    reg [7:0]  spread_ctrl_q;
    reg [7:0]  out_en_q;
    reg [7:0]  out_ctrl_q;
    reg [1:0]  state_q;
    reg [31:0] wake_cnt_q;
    reg [15:0] ss_cnt_q;
    reg        ss_dir_q;
    reg [7:0]  aw_addr_q;
    reg        aw_have_q;
    reg [31:0] w_data_q;
    reg        w_have_q;
    reg [31:0] rd_d;
    reg        rd_ok_d;
    wire       outputs_on;
    wire       aw_take;
    wire       w_take;
    wire       do_write;
    genvar     i;

    // Pins pass three flops; a change counts once the last two agree.
    always @(posedge aclk) begin
        pd_s_q   <= {pd_s_q[1:0], power_down};
        stop_s_q <= {stop_s_q[1:0], cpu_stop_n};
        fsb_s_q  <= {fsb_s_q[1:0], cpu_freq_select_b};
        fsc_s_q  <= {fsc_s_q[1:0], cpu_freq_select_c};
        if (pd_s_q[2] == pd_s_q[1]) begin
            pd_q <= pd_s_q[2];
        end
        if (stop_s_q[2] == stop_s_q[1]) begin
            stop_n_q <= stop_s_q[2];
        end
    end

    generate
        for (i = 0; i < 3; i = i + 1) begin : g_req
            always @(posedge aclk) begin
                req_s_q[i] <= {req_s_q[i][1:0], serial_ref_request_n[i]};
                if (req_s_q[i][2] == req_s_q[i][1]) begin
                    req_n_q[i] <= req_s_q[i][2];
                end
            end
        end
    endgenerate

    // Wake sequence after power-down release.
    always @(posedge aclk) begin
        if (!aresetn || pd_q) begin
            state_q    <= ST_DOWN;
            wake_cnt_q <= 32'h00000000;
        end else begin
            case (state_q)
                ST_DOWN: begin
                    state_q    <= ST_WAKE;
                    wake_cnt_q <= 32'h00000000;
                end
                ST_WAKE: begin
                    wake_cnt_q <= wake_cnt_q + 32'h00000001;
                    if (wake_cnt_q >= PD_DRIVE_CYCLES - 1) begin
                        state_q <= ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    wake_cnt_q <= wake_cnt_q + 32'h00000001;
                    if (wake_cnt_q >= STAB_CYCLES - 1) begin
                        state_q <= ST_STABLE;
                    end
                end
                ST_STABLE: state_q <= ST_STABLE;
                default:   state_q <= ST_DOWN;
            endcase
        end
    end

    assign outputs_on = (state_q == ST_DRIVE) || (state_q == ST_STABLE);

    // Output gating; every output is registered, so changes land on edges.
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_out
            always @(posedge aclk) begin
                if (!aresetn || !outputs_on || !out_en_q[`OE_CPU0_BIT - i]
                        || !pll_en_q[7]) begin
                    cpu_true[i] <= 1'b0;
                    cpu_comp[i] <= 1'b0;
                end else if (!stop_n_q && out_ctrl_q[2 - i]) begin
                    cpu_true[i] <= 1'b1;
                    cpu_comp[i] <= 1'b0;
                end else begin
                    cpu_true[i] <= cpu_phase;
                    cpu_comp[i] <= ~cpu_phase;
                end
                if (!aresetn || !outputs_on || !out_en_q[`OE_SRC0_BIT - i]
                        || req_n_q[i] || !pll_en_q[7]) begin
                    serial_ref_true[i] <= 1'b0;
                    serial_ref_comp[i] <= 1'b0;
                end else begin
                    serial_ref_true[i] <= serial_ref_phase;
                    serial_ref_comp[i] <= ~serial_ref_phase;
                end
            end
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn || !outputs_on) begin
            display_96m_true  <= 1'b0;
            display_96m_comp  <= 1'b0;
            panel_spread_true <= 1'b0;
            panel_spread_comp <= 1'b0;
            ref_out           <= 1'b0;
        end else begin
            display_96m_true  <= out_en_q[`OE_DOT_BIT] & pll_en_q[6] & display_phase;
            display_96m_comp  <= out_en_q[`OE_DOT_BIT] & pll_en_q[6] & ~display_phase;
            panel_spread_true <= out_en_q[`OE_LCD_BIT] & pll_en_q[5] & panel_phase;
            panel_spread_comp <= out_en_q[`OE_LCD_BIT] & pll_en_q[5] & ~panel_phase;
            ref_out           <= out_ctrl_q[`OE_REF_BIT] & ref_phase;
        end
    end

    // Frequency decode, spread selection and triangle profile.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_freq_code  <= 2'b00;
            cpu_freq_mhz   <= 8'h00;
            spread_code    <= 3'b000;
            spread_centre  <= 1'b0;
            spread_profile <= 7'h00;
            ss_cnt_q       <= 16'h0000;
            ss_dir_q       <= 1'b0;
            clocks_stable  <= 1'b0;
        end else begin
            clocks_stable <= (state_q == ST_STABLE);
            if (fsc_s_q[2] == fsc_s_q[1] && fsb_s_q[2] == fsb_s_q[1]) begin
                cpu_freq_code <= {fsc_s_q[2], fsb_s_q[2]};
                case ({fsc_s_q[2], fsb_s_q[2]})
                    2'b00:   cpu_freq_mhz <= 8'h85;
                    2'b01:   cpu_freq_mhz <= 8'hA7;
                    2'b10:   cpu_freq_mhz <= 8'h64;
                    default: cpu_freq_mhz <= 8'h43;
                endcase
            end
            if (spread_ctrl_q[`SPREAD_EN_BIT]) begin
                spread_code   <= spread_ctrl_q[`SPREAD_SEL_LSB +: 3];
                spread_centre <= spread_ctrl_q[`SPREAD_SEL_LSB + 2];
                if (ss_cnt_q >= `SS_STEP_CYC - 1) begin
                    ss_cnt_q <= 16'h0000;
                    if (ss_dir_q) begin
                        spread_profile <= spread_profile - 7'h01;
                        if (spread_profile == 7'h01) ss_dir_q <= 1'b0;
                    end else begin
                        spread_profile <= spread_profile + 7'h01;
                        if (spread_profile == 7'h3F) ss_dir_q <= 1'b1;
                    end
                end else begin
                    ss_cnt_q <= ss_cnt_q + 16'h0001;
                end
            end else begin
                spread_code    <= 3'b000;
                spread_centre  <= 1'b0;
                spread_profile <= 7'h00;
                ss_cnt_q       <= 16'h0000;
                ss_dir_q       <= 1'b0;
            end
        end
    end

    // AXI4-Lite write path; address and data may come in either order.
    assign aw_take  = s_axi_awvalid & s_axi_awready;
    assign w_take   = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            pll_en_q      <= `RST_PLL_ENABLE;
            spread_ctrl_q <= `RST_SPREAD_CTRL;
            out_en_q      <= `RST_OUTPUT_ENABLE;
            out_ctrl_q    <= `RST_OUTPUT_CTRL;
        end else begin
            if (aw_take) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_q     <= s_axi_wdata;
                w_have_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
                if (!s_axi_wstrb[0]) begin
                    w_have_q <= 1'b1;
                    w_data_q <= 32'h00000000;
                end
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_q)
                    `REG_PLL_ENABLE:    pll_en_q      <= w_data_q[7:0] & 8'hEF;
                    `REG_SPREAD_CTRL:   spread_ctrl_q <= w_data_q[7:0] & 8'hF8;
                    `REG_OUTPUT_ENABLE: out_en_q      <= w_data_q[7:0];
                    `REG_OUTPUT_CTRL:   out_ctrl_q    <= w_data_q[7:0] & 8'h3F;
                    `REG_STATUS:        s_axi_bresp   <= `RESP_OKAY;
                    default:            s_axi_bresp   <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read path.
    always @* begin
        rd_d    = 32'h00000000;
        rd_ok_d = 1'b1;
        case (s_axi_araddr)
            `REG_PLL_ENABLE:    rd_d = {24'h000000, pll_en_q};
            `REG_SPREAD_CTRL:   rd_d = {24'h000000, spread_ctrl_q};
            `REG_OUTPUT_ENABLE: rd_d = {24'h000000, out_en_q};
            `REG_OUTPUT_CTRL:   rd_d = {24'h000000, out_ctrl_q};
            `REG_STATUS:        rd_d = {24'h000000, stop_n_q, req_n_q, pd_q,
                                        state_q == ST_STABLE, cpu_freq_code};
            default:            rd_ok_d = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_d;
            s_axi_rresp   <= rd_ok_d ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* testbench/clock_output_partner.sv */
/*
 Far-side model: drives the pins of the block and a free-running clock phase.
 Assumes the bench calls set_pins to change the pin levels.
*/
`timescale 1ns/1ps
module clock_output_partner (
    input  wire       aclk,
    output reg        power_down,
    output reg        cpu_stop_n,
    output reg  [2:0] serial_ref_request_n,
    output reg        cpu_freq_select_b,
    output reg        cpu_freq_select_c,
    output reg        phase
);
    initial begin
        {power_down, serial_ref_request_n, cpu_freq_select_c, cpu_freq_select_b} = 6'h00;
        cpu_stop_n = 1'b1;
        phase = 1'b0;
    end
    always @(posedge aclk) begin
        phase <= ~phase;
    end
    // Changes all pin levels together just after a rising edge.
    task set_pins(input pd, input stop_n, input [2:0] req_n, input [1:0] sel);
        @(posedge aclk);
        power_down <= pd;
        cpu_stop_n <= stop_n;
        serial_ref_request_n <= req_n;
        {cpu_freq_select_c, cpu_freq_select_b} <= sel;
    endtask
endmodule

/* testbench/clock_output_control_sva.sv */
/*
 Assertion checker for the clock output control block.
 Assumes one aclk domain and the block's own port names.
*/
`timescale 1ns/1ps
module clock_output_control_sva #(
    parameter PD_DRIVE_CYCLES = 20,
    parameter STAB_CYCLES     = 50
) (
    input wire        aclk,
    input wire        aresetn,
    input wire        power_down,
    input wire        cpu_freq_select_b,
    input wire        cpu_freq_select_c,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        spread_centre,
    input wire        clocks_stable,
    input wire [31:0] s_axi_rdata,
    input wire [2:0]  serial_ref_request_n,
    input wire [2:0]  cpu_true,
    input wire [2:0]  cpu_comp,
    input wire [2:0]  spread_code,
    input wire [2:0]  serial_ref_true,
    input wire [2:0]  serial_ref_comp,
    input wire        display_96m_true,
    input wire        panel_spread_true,
    input wire        ref_out,
    input wire [1:0]  cpu_freq_code,
    input wire [7:0]  cpu_freq_mhz
);
    localparam [31:0] MHZ = 32'h4364A785;
    reg [2:0] up_q;
    always @(posedge aclk) begin
        if (!aresetn) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_resp_due;
        ##[1:2] s_axi_bvalid;
    endsequence
    a_write_answer: assert property (s_both_taken |-> s_resp_due)
        else $error("write response missing");
    a_write_refused: assert property (s_both_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_pd_outputs_low: assert property (power_down[*8] |-> !clocks_stable &&
        {cpu_true, cpu_comp, serial_ref_true, serial_ref_comp, display_96m_true,
         panel_spread_true, ref_out} == 15'h0) else $error("output alive in power-down");
    a_request_off: assert property (serial_ref_request_n[1][*8] |->
        !serial_ref_true[1] && !serial_ref_comp[1]) else $error("request ignored");
    a_pair_legs: assert property (!(|(cpu_true & cpu_comp)) &&
        !(|(serial_ref_true & serial_ref_comp))) else $error("both legs high");
    a_freq_decode: assert property ($stable({cpu_freq_select_c, cpu_freq_select_b})[*8]
        |-> cpu_freq_code == {cpu_freq_select_c, cpu_freq_select_b}) else $error("bad code");
    a_freq_value: assert property (up_q == 3'h7 && $stable(cpu_freq_code)
        |-> cpu_freq_mhz == MHZ[8*cpu_freq_code +: 8]) else $error("bad frequency");
    a_centre_bit: assert property (up_q == 3'h7 && $stable(spread_code)
        |-> spread_centre == spread_code[2]) else $error("bad spread kind");
endmodule
bind clock_output_control clock_output_control_sva #(.PD_DRIVE_CYCLES(PD_DRIVE_CYCLES),
    .STAB_CYCLES(STAB_CYCLES)) sva_i (.*);

/* testbench/tb.sv */
/*
 Self-checking bench for the clock output control block.
 Assumes the partner model and a 40 MHz aclk.
*/
`timescale 1ns/1ps
module tb;
    localparam PDC = 20;
    localparam STC = 50;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [13:0] lvl, tog;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp, cpu_freq_code;
    wire [31:0] s_axi_rdata;
    wire        power_down, cpu_stop_n, cpu_freq_select_b, cpu_freq_select_c, phase;
    wire [2:0]  serial_ref_request_n, cpu_true, cpu_comp, serial_ref_true, serial_ref_comp;
    wire [2:0]  spread_code;
    wire        display_96m_true, display_96m_comp, panel_spread_true, panel_spread_comp;
    wire        ref_out, spread_centre, clocks_stable;
    wire [7:0]  cpu_freq_mhz;
    wire [6:0]  spread_profile;
    wire [13:0] outs = {cpu_true, cpu_comp, serial_ref_true, serial_ref_comp,
                        display_96m_true, panel_spread_true};
    integer     errors, checked;
    clock_output_partner clock_output_partner_i (.aclk(aclk), .phase(phase), .*);
    clock_output_control #(.PD_DRIVE_CYCLES(PDC), .STAB_CYCLES(STC)) clock_output_control_i (
        .s_axi_wstrb(4'hF), .cpu_phase(phase), .serial_ref_phase(phase),
        .display_phase(phase), .panel_phase(phase), .ref_phase(phase), .*);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task test_done;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task hang;
        chk(32'h0, 32'h1);
        test_done;
    endtask
    task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 50) hang;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 50) hang;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask
    // Samples levels at one edge and which outputs toggled by the next.
    task snap;
        @(posedge aclk);
        #1 lvl = outs;
        @(posedge aclk);
        #1 tog = outs ^ lvl;
    endtask
    task s_regs;
        axi_rd(8'h00, 32'hEF, 2'b00);
        axi_rd(8'h04, 32'hC0, 2'b00);
        axi_rd(8'h08, 32'hFF, 2'b00);
        axi_rd(8'h0C, 32'h30, 2'b00);
        axi_rd(8'h10, 32'h84, 2'b00);
        axi_rd(8'h20, 32'h00, 2'b10);
        axi_wr(8'h20, 32'hFF, 2'b10);
        axi_wr(8'h0C, 32'hABCD0037, 2'b00);
        axi_rd(8'h0C, 32'h37, 2'b00);
    endtask
    task s_freq;
        integer k;
        for (k = 0; k < 4; k = k + 1) begin
            clock_output_partner_i.set_pins(1'b0, 1'b1, 3'h0, k[1:0]);
            repeat (8) @(posedge aclk);
            chk(cpu_freq_code, k);
            chk(cpu_freq_mhz, 32'h4364A785 >> (8 * k) & 32'hFF);
        end
    endtask
    task s_spread;
        integer k;
        reg [6:0] p0;
        for (k = 0; k < 8; k = k + 1) begin
            axi_wr(8'h04, 32'h40 | (k << 3), 2'b00);
            repeat (3) @(posedge aclk);
            chk(spread_code, k);
            chk(spread_centre, k >> 2);
        end
        p0 = spread_profile;
        repeat (200) @(posedge aclk);
        chk({31'h0, spread_profile - p0 >= 7'h13 && spread_profile - p0 <= 7'h15}, 1);
        axi_wr(8'h04, 32'h38, 2'b00);
        repeat (3) @(posedge aclk);
        chk({spread_centre, spread_code, spread_profile}, 0);
    endtask
    task s_cpu;
        snap;
        chk(tog, 14'h3FFF);
        chk(display_96m_true ^ display_96m_comp, 1'b1);
        chk({panel_spread_true ^ panel_spread_comp, ref_out ^ phase}, 2'h3);
        axi_wr(8'h0C, 32'h34, 2'b00);
        clock_output_partner_i.set_pins(1'b0, 1'b0, 3'h0, 2'h0);
        repeat (6) @(posedge aclk);
        snap;
        chk(tog, 14'h36FF);
        chk(lvl & 14'h0900, 14'h0800);
        clock_output_partner_i.set_pins(1'b0, 1'b1, 3'h0, 2'h0);
        repeat (6) @(posedge aclk);
        snap;
        chk(tog, 14'h3FFF);
        axi_wr(8'h08, 32'h7F, 2'b00);
        snap;
        chk(tog, 14'h36FF);
        chk(lvl & 14'h0900, 14'h0000);
        axi_wr(8'h08, 32'hFF, 2'b00);
    endtask
    task s_req;
        clock_output_partner_i.set_pins(1'b0, 1'b1, 3'h2, 2'h0);
        repeat (6) @(posedge aclk);
        snap;
        chk(tog, 14'h3FB7);
        chk(lvl & 14'h0048, 14'h0000);
        clock_output_partner_i.set_pins(1'b0, 1'b1, 3'h0, 2'h0);
        repeat (6) @(posedge aclk);
        snap;
        chk(tog, 14'h3FFF);
    endtask
    task s_pd;
        integer n, on_at, st_at;
        clock_output_partner_i.set_pins(1'b1, 1'b1, 3'h0, 2'h0);
        repeat (10) @(posedge aclk);
        snap;
        chk({lvl, tog, clocks_stable}, 0);
        clock_output_partner_i.set_pins(1'b0, 1'b1, 3'h0, 2'h0);
        on_at = 0;
        st_at = 0;
        for (n = 1; n < 200 && st_at == 0; n = n + 1) begin
            @(posedge aclk);
            if (on_at == 0 && outs != 14'h0000) on_at = n;
            if (clocks_stable === 1'b1) st_at = n;
        end
        if (st_at == 0) hang;
        chk({31'h0, on_at >= PDC && on_at <= PDC + 8}, 1);
        chk({31'h0, st_at >= STC && st_at <= STC + 10}, 1);
    endtask
    initial begin
        errors = 0;
        checked = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (120) @(posedge aclk);
        s_regs;
        s_freq;
        s_spread;
        s_cpu;
        s_req;
        s_pd;
        test_done;
    end
endmodule
